// *** tac_abort_ctl.sv ***
/*
 * Abort-side controller of a restricted transactional memory unit:
 * abort status word, commit/discard, debug aborts, suspend regions,
 * nesting and instruction abort policy, plus an APB register slave.
 * Assumes the core presents one classified instruction per cycle on
 * clk_sys and acts on the registered answer one cycle later.
 */
// Added by the designer: the register addresses and the APB register port.
// Functional notes
// [RULE1] status bit 0 set only for explicit software abort
// [RULE2] bit 1 is retry hint, never set together with bit 0
// [RULE3] bit 2 set on conflicting access by another processor
// [RULE4] bit 3 set when tracking buffer overflowed
// [RULE5] bit 4 set on debug or breakpoint exception
// [RULE6] bit 5 set when abort hit inside nested region
// [RULE7] bits 23:6 zero, bits 31:24 abort argument when bit 0 set
// [RULE8] status holds causes only; may be all zero
// [RULE9] commit is atomic and ordered like a locked instruction
// [RULE10] begin has no fence; abort discards all region updates
// [RULE11] default debug abort: fallback, restored state, bit 4 set
// [RULE12] advanced debug: roll back before begin, restore status, raise debug
// [RULE13] advanced debug clears debug status bit 16
// [RULE14] suspend stops load tracking, resume restarts it
// [RULE15] suspended loads still tracked if already in read set
// [RULE16] begin or end inside suspend region aborts
// [RULE17] suspend inside suspend region aborts
// [RULE18] aborted updates never visible, only commit updates state
// [RULE19] direction instructions abort only when they change the flag
// [RULE20] abort, query, pause and enclave leaves always abort
// [RULE21] optional abort class; software must not rely on it
// [RULE22] safe operations never abort, at any privilege level
// [RULE23] nesting counts begins and ends, commit at zero, abort over maximum
// [RULE24] without the feature, begin, end and abort are undefined
// [RULE25] status word written with the fallback transfer
// [RULE26] one suspend flag, set, cleared by resume, abort or commit
`default_nettype none
`include "tac_consts.svh"

module tac_abort_ctl (
    input  wire logic                   clk_sys,
    input  wire logic                   rstn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`TAC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output var  logic [31:0]            prdata,
    output var  logic                   pready,
    output var  logic                   pslverr,
    input  wire tac_pkg::tac_instr_type instr,
    input  wire tac_pkg::tac_event_type evt,
    input  wire logic [31:0]            status_prev,
    input  wire logic                   debug_control_reg_bit11,
    input  wire logic                   debug_ctl_msr_bit15,
    output var  tac_pkg::tac_resp_type  resp,
    output var  logic                   ld_add_readset,
    output var  logic                   txn_active,
    output var  logic                   debug_status_bit16
);
    import tac_pkg::*;

    tac_state_type            st_reg;
    logic [`TAC_DEPTH_W-1:0]  depth_reg;
    logic                     susp_reg;
    logic [31:0]              saved_reg;
    logic [31:0]              status_reg;
    logic [2:0]               ctrl_reg;
    logic                     dbg16_reg;
    tac_resp_type             resp_reg;
    logic                     ldadd_reg;
    logic [31:0]              prdata_reg;
    logic                     pslverr_reg;

    logic                     in_txn;
    logic                     rtm_en;
    logic                     ldtrk_en;
    logic                     feat_ud;
    logic                     enter;
    logic                     leave;
    logic                     abort_now;
    logic                     dbg_hit;
    logic                     adv;
    logic                     commit;
    logic                     susp_set;
    logic                     susp_clr;
    logic [31:0]              cause;
    logic                     wr_en;
    logic                     setup;

    function automatic logic addr_hit(input logic [`TAC_ADDR_W-1:0] a);
        addr_hit = (a == `TAC_OFF_STATUS) || (a == `TAC_OFF_CTRL) ||
                   (a == `TAC_OFF_STATE) || (a == `TAC_OFF_DBGSTS);
    endfunction

    assign in_txn   = (st_reg == TAC_ST_TXN);
    assign rtm_en   = ctrl_reg[`TAC_CTRL_RTM_EN];
    assign ldtrk_en = ctrl_reg[`TAC_CTRL_LDTRK_EN];
    assign adv      = dbg_hit && debug_control_reg_bit11 && debug_ctl_msr_bit15; // [RULE12]
    // an abort in the same cycle as the closing end wins over the commit
    assign commit   = leave && (depth_reg == `TAC_DEPTH_W'(1)) && !abort_now; // [RULE23]

    always_comb begin
        feat_ud   = 1'b0;
        enter     = 1'b0;
        leave     = 1'b0;
        abort_now = 1'b0;
        dbg_hit   = 1'b0;
        susp_set  = 1'b0;
        susp_clr  = 1'b0;
        cause     = 32'h0000_0000;
        if (instr.valid) begin
            case (instr.op)
                TAC_OP_BEGIN: begin
                    if (!rtm_en) begin
                        feat_ud = 1'b1; // [RULE24]
                    end else if (in_txn && susp_reg) begin
                        abort_now = 1'b1; // [RULE16]
                    end else if (in_txn && depth_reg == `TAC_MAX_NEST) begin
                        abort_now = 1'b1; // [RULE23]
                    end else begin
                        enter = 1'b1; // [RULE10]
                    end
                end
                TAC_OP_END: begin
                    if (!rtm_en || !in_txn) begin
                        feat_ud = 1'b1; // [RULE24]
                    end else if (susp_reg) begin
                        abort_now = 1'b1; // [RULE16]
                    end else begin
                        leave = 1'b1; // [RULE23]
                    end
                end
                TAC_OP_EXPLICIT_ABORT_INSTR: begin
                    if (!rtm_en) begin
                        feat_ud = 1'b1; // [RULE24]
                    end else if (in_txn) begin
                        abort_now = 1'b1; // [RULE20]
                        cause[`TAC_SW_EXPLICIT_ABORT_INSTR] = 1'b1; // [RULE1]
                        cause[31:`TAC_SW_ARG_LSB] = instr.imm; // [RULE7]
                    end
                end
                // no cause bit: such aborts may leave an all-zero word
                TAC_OP_FQUERY, TAC_OP_PAUSE, TAC_OP_ENCLAVE_SUPERVISOR_LEAF, TAC_OP_ENCLAVE_USER_LEAF: begin
                    abort_now = in_txn; // [RULE20] [RULE8]
                end
                TAC_OP_SUSPEND: begin
                    if (!ldtrk_en) begin
                        feat_ud = 1'b1;
                    end else if (in_txn && susp_reg) begin
                        abort_now = 1'b1; // [RULE17]
                    end else begin
                        susp_set = in_txn; // [RULE14]
                    end
                end
                TAC_OP_RESUME: begin
                    feat_ud  = !ldtrk_en;
                    susp_clr = ldtrk_en; // [RULE14]
                end
                TAC_OP_CLD: begin
                    abort_now = in_txn && instr.df; // [RULE19]
                end
                TAC_OP_STD: begin
                    abort_now = in_txn && !instr.df; // [RULE19]
                end
                TAC_OP_OPTIONAL: begin
                    // software steers this class; code must never depend on it
                    abort_now = in_txn && ctrl_reg[`TAC_CTRL_OPT_ABORT]; // [RULE21]
                end
                TAC_OP_DBG, TAC_OP_BP: begin
                    if (in_txn) begin
                        abort_now = 1'b1; // [RULE11]
                        dbg_hit   = 1'b1;
                        cause[`TAC_SW_DEBUG] = 1'b1; // [RULE5]
                    end
                end
                default: begin
                    abort_now = 1'b0; // [RULE22]
                end
            endcase
        end
        if (in_txn && evt.conflict) begin
            abort_now = 1'b1;
            cause[`TAC_SW_CONFLICT] = 1'b1; // [RULE3]
        end
        if (in_txn && evt.overflow) begin
            abort_now = 1'b1;
            cause[`TAC_SW_OVERFLOW] = 1'b1; // [RULE4]
        end
        if (abort_now && depth_reg > `TAC_DEPTH_W'(1)) begin
            cause[`TAC_SW_NESTED] = 1'b1; // [RULE6]
        end
        // only a conflict hints at retry, and never beside an explicit abort
        cause[`TAC_SW_RETRY] = cause[`TAC_SW_CONFLICT] & ~cause[`TAC_SW_EXPLICIT_ABORT_INSTR]; // [RULE2]
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st_reg    <= TAC_ST_IDLE;
            depth_reg <= '0;
        end else if (abort_now) begin
            st_reg    <= TAC_ST_IDLE;
            depth_reg <= '0;
        end else if (enter) begin
            st_reg    <= TAC_ST_TXN;
            depth_reg <= depth_reg + `TAC_DEPTH_W'(1); // [RULE23]
        end else if (leave) begin
            depth_reg <= depth_reg - `TAC_DEPTH_W'(1); // [RULE23]
            if (commit) begin
                st_reg <= TAC_ST_IDLE;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            susp_reg <= 1'b0;
        end else if (abort_now || commit || susp_clr) begin
            susp_reg <= 1'b0; // [RULE26]
        end else if (susp_set) begin
            susp_reg <= 1'b1; // [RULE26]
        end
    end

    // status value (status_prev) before the outermost begin, for debugger rollback
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            saved_reg <= 32'h0000_0000;
        end else if (enter && !in_txn) begin
            saved_reg <= status_prev;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            resp_reg <= '0;
        end else begin
            resp_reg <= '0;
            resp_reg.raise_ud <= feat_ud; // [RULE24]
            if (abort_now) begin
                resp_reg.abort     <= 1'b1;
                resp_reg.discard   <= 1'b1; // [RULE10] [RULE18]
                resp_reg.status_wr <= 1'b1;
                if (adv) begin
                    resp_reg.rollback    <= 1'b1; // [RULE12]
                    resp_reg.raise_db    <= 1'b1; // [RULE12]
                    resp_reg.status_data <= saved_reg; // [RULE12]
                end else begin
                    resp_reg.fallback    <= 1'b1; // [RULE11]
                    resp_reg.status_data <= cause; // [RULE25] [RULE7]
                end
            end else if (commit) begin
                resp_reg.commit     <= 1'b1; // [RULE9] [RULE18]
                resp_reg.lock_fence <= 1'b1; // [RULE9]
            end
        end
    end

    // suspended loads skip the read set unless already tracked there
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ldadd_reg <= 1'b0;
        end else begin
            ldadd_reg <= evt.ld_valid && in_txn &&
                         (!susp_reg || evt.ld_in_readset); // [RULE14] [RULE15]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            status_reg <= 32'h0000_0000;
        end else if (abort_now && !adv) begin
            status_reg <= cause; // [RULE25]
        end
    end

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ctrl_reg <= `TAC_CTRL_RST;
        end else if (wr_en && paddr == `TAC_OFF_CTRL) begin
            ctrl_reg <= pwdata[2:0];
        end
    end

    // hardware clear beats a software set landing in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            dbg16_reg <= 1'b1;
        end else if (abort_now && adv) begin
            dbg16_reg <= 1'b0; // [RULE13]
        end else if (wr_en && paddr == `TAC_OFF_DBGSTS && pwdata[`TAC_DBGSTS_BIT]) begin
            dbg16_reg <= 1'b1;
        end
    end

    // read data is latched in the setup cycle so the access needs no wait
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (setup) begin
            pslverr_reg <= !addr_hit(paddr);
            prdata_reg  <= 32'h0000_0000;
            case (paddr)
                `TAC_OFF_STATUS: begin
                    prdata_reg <= status_reg;
                end
                `TAC_OFF_CTRL: begin
                    prdata_reg[2:0] <= ctrl_reg;
                end
                `TAC_OFF_STATE: begin
                    prdata_reg[`TAC_ST_TXN_BIT]  <= in_txn;
                    prdata_reg[`TAC_ST_SUSP_BIT] <= susp_reg;
                    prdata_reg[`TAC_ST_DEPTH_LSB +: `TAC_DEPTH_W] <= depth_reg;
                end
                `TAC_OFF_DBGSTS: begin
                    prdata_reg[`TAC_DBGSTS_BIT] <= dbg16_reg;
                end
                default: begin
                    prdata_reg <= 32'h0000_0000;
                end
            endcase
        end
    end

    assign pready             = 1'b1;
    assign prdata             = prdata_reg;
    assign pslverr            = pslverr_reg && psel && penable;
    assign resp               = resp_reg;
    assign ld_add_readset     = ldadd_reg;
    assign txn_active         = in_txn;
    assign debug_status_bit16 = dbg16_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    chk_explicit_abort_instr_word: assert property ( // [RULE1]
        instr.valid && instr.op == TAC_OP_EXPLICIT_ABORT_INSTR && in_txn && rtm_en
        |=> resp.fallback && resp.status_data[0] && !resp.status_data[1]
            && resp.status_data[31:24] == $past(instr.imm))
        else $error("explicit abort word wrong");

    chk_retry_excl: assert property ( // [RULE2]
        resp.fallback |-> !(resp.status_data[0] && resp.status_data[1]))
        else $error("retry hint beside explicit abort");

    chk_conflict_bit: assert property ( // [RULE3]
        in_txn && evt.conflict && !adv
        |=> resp.abort && resp.status_data[2] && status_reg[2])
        else $error("conflict cause not reported");

    chk_reserved_zero: assert property ( // [RULE7]
        resp.fallback |-> resp.status_data[23:6] == 18'h00000)
        else $error("reserved status bits set");

    chk_adv_rollback: assert property ( // [RULE12]
        abort_now && adv |=> resp.rollback && resp.raise_db && !resp.fallback
            && resp.status_data == $past(saved_reg) && !debug_status_bit16)
        else $error("advanced debug rollback wrong");

    chk_susp_nest: assert property ( // [RULE17]
        instr.valid && instr.op == TAC_OP_SUSPEND && in_txn && susp_reg && ldtrk_en
        |=> resp.abort && !txn_active)
        else $error("nested suspend did not abort");

    chk_begin_susp: assert property ( // [RULE16]
        instr.valid && (instr.op == TAC_OP_BEGIN || instr.op == TAC_OP_END)
            && in_txn && susp_reg && rtm_en |=> resp.abort)
        else $error("begin or end in suspend region did not abort");

    chk_df_hold: assert property ( // [RULE19]
        instr.valid && in_txn && !evt.conflict && !evt.overflow
            && ((instr.op == TAC_OP_CLD && !instr.df) || (instr.op == TAC_OP_STD && instr.df))
        |=> !resp.abort)
        else $error("unchanged direction flag aborted");

    chk_susp_clear: assert property ( // [RULE26]
        resp.abort || resp.commit |-> !susp_reg)
        else $error("suspend flag survived end of transaction");

    chk_commit_fence: assert property ( // [RULE9]
        resp.commit |-> resp.lock_fence && !resp.discard && !txn_active)
        else $error("commit without fence");

    chk_no_feature: assert property ( // [RULE24]
        instr.valid && instr.op == TAC_OP_BEGIN && !rtm_en |=> resp.raise_ud && !txn_active)
        else $error("begin without feature not undefined");

    cov_commit: cover property (resp.commit);
    cov_explicit_abort_instr: cover property (resp.fallback && resp.status_data[0]);
    cov_adv_dbg: cover property (resp.rollback);
    cov_suspend: cover property (susp_reg ##1 !susp_reg && txn_active);

endmodule // tac_abort_ctl

`default_nettype wire

// *** tac_consts.svh ***
/*
 * Offsets, field positions, reset values and limits of the transactional
 * abort controller. Assumes inclusion by the design file and the bench.
 */
`ifndef TAC_CONSTS_SVH
`define TAC_CONSTS_SVH

`define TAC_ADDR_W          12
`define TAC_OFF_STATUS      12'h000
`define TAC_OFF_CTRL        12'h004
`define TAC_OFF_STATE       12'h008
`define TAC_OFF_DBGSTS      12'h00C

`define TAC_CTRL_RST        3'h3
`define TAC_CTRL_RTM_EN     0
`define TAC_CTRL_LDTRK_EN   1
`define TAC_CTRL_OPT_ABORT  2

`define TAC_ST_TXN_BIT      0
`define TAC_ST_SUSP_BIT     1
`define TAC_ST_DEPTH_LSB    4

`define TAC_SW_EXPLICIT_ABORT_INSTR       0
`define TAC_SW_RETRY        1
`define TAC_SW_CONFLICT     2
`define TAC_SW_OVERFLOW     3
`define TAC_SW_DEBUG        4
`define TAC_SW_NESTED       5
`define TAC_SW_ARG_LSB      24

`define TAC_DBGSTS_BIT      16
`define TAC_DEPTH_W         3
`define TAC_MAX_NEST        3'h7

`endif

// *** tac_pkg.sv ***
/*
 * Types of the transactional abort controller: instruction classes,
 * core-side request and answer carriers. Assumes nothing else.
 */
`default_nettype none

package tac_pkg;

    typedef enum logic [3:0] {
        TAC_OP_NONE     = 4'h0,
        TAC_OP_BEGIN    = 4'h1,
        TAC_OP_END      = 4'h2,
        TAC_OP_EXPLICIT_ABORT_INSTR   = 4'h3,
        TAC_OP_FQUERY   = 4'h4,
        TAC_OP_PAUSE    = 4'h5,
        TAC_OP_ENCLAVE_SUPERVISOR_LEAF    = 4'h6,
        TAC_OP_ENCLAVE_USER_LEAF    = 4'h7,
        TAC_OP_SUSPEND  = 4'h8,
        TAC_OP_RESUME   = 4'h9,
        TAC_OP_CLD      = 4'hA,
        TAC_OP_STD      = 4'hB,
        TAC_OP_OPTIONAL = 4'hC,
        TAC_OP_DBG      = 4'hD,
        TAC_OP_BP       = 4'hE,
        TAC_OP_SAFE     = 4'hF
    } tac_op_type;

    typedef enum logic [0:0] {
        TAC_ST_IDLE = 1'b0,
        TAC_ST_TXN  = 1'b1
    } tac_state_type;

    typedef struct packed {
        logic       valid;
        tac_op_type op;
        logic [7:0] imm;
        logic       df;
    } tac_instr_type;

    typedef struct packed {
        logic conflict;
        logic overflow;
        logic ld_valid;
        logic ld_in_readset;
    } tac_event_type;

    typedef struct packed {
        logic        abort;
        logic        fallback;
        logic        rollback;
        logic        raise_db;
        logic        raise_ud;
        logic        commit;
        logic        lock_fence;
        logic        discard;
        logic        status_wr;
        logic [31:0] status_data;
    } tac_resp_type;

endpackage : tac_pkg

`default_nettype wire

// *** tb_txn_abort_status_control.sv ***
/* Self-checking bench of the transactional abort controller.
   Assumes tac_pkg, tac_consts.svh and tac_abort_ctl are compiled first. */
`default_nettype none
`include "tac_consts.svh"

module tb_txn_abort_status_control import tac_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [8:0] F_AB = 9'h183;
    localparam logic [8:0] F_CM = 9'h00C;
    localparam logic [8:0] F_DB = 9'h163;
    localparam logic [8:0] F_UD = 9'h010;

    logic          clk_sys, rstn, psel, penable, pwrite, pready, pslverr;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, status_prev, rd;
    logic          dbg11, dbg15, ld_add_readset, txn_active, debug_status_bit16, err, ld;
    tac_instr_type instr;
    tac_event_type evt;
    tac_resp_type  resp, r;
    int            n_errors, n_compared;

    tac_abort_ctl dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .instr(instr), .evt(evt), .status_prev(status_prev),
        .debug_control_reg_bit11(dbg11), .debug_ctl_msr_bit15(dbg15), .resp(resp),
        .ld_add_readset(ld_add_readset), .txn_active(txn_active),
        .debug_status_bit16(debug_status_bit16));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic end_sim();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int i;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (pready === 1'b1)
                break;
        end
        if (i == 20) begin
            n_errors++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // answer is registered: look 1 ns after the edge that takes the op
    task automatic go(input tac_op_type op, input logic [7:0] imm = 8'h00,
                      input logic df = 1'b0, input logic [3:0] ev = 4'h0);
        @(posedge clk_sys);
        instr <= '{valid: op != TAC_OP_NONE, op: op, imm: imm, df: df};
        evt   <= tac_event_type'(ev);
        @(posedge clk_sys);
        instr <= '0;
        evt   <= '0;
        #1;
        r  = resp;
        ld = ld_add_readset;
    endtask

    task automatic exp_r(input logic [8:0] fl);
        chk(32'(r[40:32]), 32'(fl));
    endtask

    task automatic t_reset();
        chk(32'(debug_status_bit16), 32'h1);
        chk(32'(txn_active), 32'h0);
        apb(1'b0, `TAC_OFF_CTRL, 32'h0);
        chk(rd, 32'h3);
        apb(1'b0, 12'h010, 32'h0);
        chk(32'(err), 32'h1);
    endtask

    task automatic t_commit();
        go(TAC_OP_BEGIN);
        exp_r(9'h000);
        go(TAC_OP_BEGIN);
        go(TAC_OP_END);
        exp_r(9'h000);
        chk(32'(txn_active), 32'h1);
        go(TAC_OP_END);
        exp_r(F_CM);
        chk(32'(txn_active), 32'h0);
        go(TAC_OP_END);
        exp_r(F_UD);
    endtask

    task automatic t_explicit_abort_instr();
        go(TAC_OP_BEGIN);
        go(TAC_OP_EXPLICIT_ABORT_INSTR, 8'h5A);
        exp_r(F_AB);
        chk(r.status_data, 32'h5A000001);
        apb(1'b1, `TAC_OFF_STATUS, 32'hFFFFFFFF);
        apb(1'b0, `TAC_OFF_STATUS, 32'h0);
        chk(rd, 32'h5A000001);
    endtask

    task automatic t_causes();
        go(TAC_OP_BEGIN);
        go(TAC_OP_NONE, 8'h00, 1'b0, 4'h8);
        chk(r.status_data, 32'h6);
        go(TAC_OP_BEGIN);
        go(TAC_OP_NONE, 8'h00, 1'b0, 4'h4);
        exp_r(F_AB);
        chk(r.status_data, 32'h8);
        go(TAC_OP_BEGIN);
        go(TAC_OP_BEGIN);
        go(TAC_OP_NONE, 8'h00, 1'b0, 4'h8);
        chk(r.status_data, 32'h26);
    endtask

    task automatic t_always();
        tac_op_type ops[4] = '{TAC_OP_FQUERY, TAC_OP_PAUSE, TAC_OP_ENCLAVE_SUPERVISOR_LEAF, TAC_OP_ENCLAVE_USER_LEAF};
        foreach (ops[i]) begin
            go(TAC_OP_BEGIN);
            go(ops[i]);
            exp_r(F_AB);
            chk(r.status_data, 32'h0);
        end
        go(TAC_OP_FQUERY);
        exp_r(9'h000);
    endtask

    task automatic t_dir();
        go(TAC_OP_BEGIN);
        go(TAC_OP_STD, 8'h00, 1'b1);
        exp_r(9'h000);
        go(TAC_OP_CLD, 8'h00, 1'b0);
        exp_r(9'h000);
        go(TAC_OP_SAFE);
        exp_r(9'h000);
        chk(32'(txn_active), 32'h1);
        go(TAC_OP_STD, 8'h00, 1'b0);
        exp_r(F_AB);
        go(TAC_OP_BEGIN);
        go(TAC_OP_CLD, 8'h00, 1'b1);
        exp_r(F_AB);
    endtask

    task automatic t_debug();
        tac_op_type ops[2] = '{TAC_OP_DBG, TAC_OP_BP};
        foreach (ops[i]) begin
            go(TAC_OP_BEGIN);
            go(ops[i]);
            exp_r(F_AB);
            chk(r.status_data, 32'h10);
        end
    endtask

    task automatic t_adv();
        dbg11 <= 1'b1;
        dbg15 <= 1'b1;
        status_prev <= 32'h12345678;
        go(TAC_OP_BEGIN);
        status_prev <= 32'h0;
        go(TAC_OP_BP);
        exp_r(F_DB);
        chk(r.status_data, 32'h12345678);
        chk(32'(debug_status_bit16), 32'h0);
        apb(1'b0, `TAC_OFF_STATUS, 32'h0);
        chk(rd, 32'h10);
        dbg11 <= 1'b0;
        dbg15 <= 1'b0;
        apb(1'b1, `TAC_OFF_DBGSTS, 32'h00010000);
    endtask

    task automatic t_susp();
        go(TAC_OP_BEGIN);
        go(TAC_OP_NONE, 8'h00, 1'b0, 4'h2);
        chk(32'(ld), 32'h1);
        go(TAC_OP_SUSPEND);
        go(TAC_OP_NONE, 8'h00, 1'b0, 4'h2);
        chk(32'(ld), 32'h0);
        go(TAC_OP_NONE, 8'h00, 1'b0, 4'h3);
        chk(32'(ld), 32'h1);
        apb(1'b0, `TAC_OFF_STATE, 32'h0);
        chk(rd, 32'h13);
        go(TAC_OP_RESUME);
        go(TAC_OP_NONE, 8'h00, 1'b0, 4'h2);
        chk(32'(ld), 32'h1);
        go(TAC_OP_SUSPEND);
        go(TAC_OP_SUSPEND);
        exp_r(F_AB);
        apb(1'b0, `TAC_OFF_STATE, 32'h0);
        chk(rd, 32'h0);
        go(TAC_OP_BEGIN);
        go(TAC_OP_SUSPEND);
        go(TAC_OP_BEGIN);
        exp_r(F_AB);
        go(TAC_OP_BEGIN);
        go(TAC_OP_SUSPEND);
        go(TAC_OP_END);
        exp_r(F_AB);
    endtask

    task automatic t_nest();
        repeat (7) go(TAC_OP_BEGIN);
        exp_r(9'h000);
        go(TAC_OP_BEGIN);
        exp_r(F_AB);
        chk(32'(txn_active), 32'h0);
    endtask

    task automatic t_feature();
        tac_op_type ops[3] = '{TAC_OP_BEGIN, TAC_OP_END, TAC_OP_EXPLICIT_ABORT_INSTR};
        apb(1'b1, `TAC_OFF_CTRL, 32'h0);
        foreach (ops[i]) begin
            go(ops[i]);
            exp_r(F_UD);
        end
        apb(1'b1, `TAC_OFF_CTRL, 32'h7);
        go(TAC_OP_BEGIN);
        go(TAC_OP_OPTIONAL);
        exp_r(F_AB);
        apb(1'b1, `TAC_OFF_CTRL, 32'h3);
        go(TAC_OP_BEGIN);
        go(TAC_OP_OPTIONAL);
        exp_r(9'h000);
        go(TAC_OP_END);
        exp_r(F_CM);
    endtask

    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        instr = '0;
        evt = '0;
        status_prev = '0;
        dbg11 = 1'b0;
        dbg15 = 1'b0;
        n_errors = 0;
        n_compared = 0;
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset();
        t_commit();
        t_explicit_abort_instr();
        t_causes();
        t_always();
        t_dir();
        t_debug();
        t_adv();
        @(posedge clk_sys);
        chk(32'(debug_status_bit16), 32'h1);
        t_susp();
        t_nest();
        t_feature();
        end_sim();
    end
endmodule // tb_txn_abort_status_control

`default_nettype wire
